// [inc/ppfs_pkg.sv]
package ppfs_pkg;
   // Register word addresses (byte address = 4 * index)
   localparam logic [2:0] PPFS_IDX_BIT_RATE = 3'h0;
   localparam logic [2:0] PPFS_IDX_DIR = 3'h1;
   localparam logic [2:0] PPFS_IDX_FUNC_4_7 = 3'h2;
   localparam logic [2:0] PPFS_IDX_FUNC_8_11 = 3'h3;
   localparam logic [2:0] PPFS_IDX_PRIO = 3'h4;
   localparam logic [2:0] PPFS_IDX_PIN_IN = 3'h5;
   localparam logic [2:0] PPFS_IDX_PIN_OUT = 3'h6;

   // Reset values
   localparam logic [7:0] PPFS_RST_BIT_RATE = 8'h00;
   localparam logic [15:0] PPFS_RST_DIR = 16'h0000;
   localparam logic [15:0] PPFS_RST_FUNC = 16'h0000;
   localparam logic [15:0] PPFS_RST_PRIO = 16'h0000;
   localparam logic [15:0] PPFS_RST_PIN_OUT = 16'h0000;
   localparam logic [15:0] PPFS_RST_SYNC = 16'h0000;
   localparam logic [31:0] PPFS_RST_READ = 32'h0000_0000;

   // Priority field of the serial interface interrupts
   localparam int PPFS_PRIO_LSB = 0;
   localparam int PPFS_PRIO_W = 4;

   // Function field layout
   localparam logic [15:0] PPFS_FUNC_MASK = 16'h7777;
   localparam int PPFS_FUNC_W = 3;
   localparam int PPFS_TX_PIN = 5;
   localparam int PPFS_RX_PIN = 11;
   localparam int PPFS_TX_LSB = 4;
   localparam int PPFS_RX_LSB = 12;
   localparam logic [2:0] PPFS_FN_PORT = 3'h0;
   localparam logic [2:0] PPFS_FN_TX = 3'h2;
   localparam logic [2:0] PPFS_FN_RX = 3'h3;
   localparam int PPFS_FIELDS_PER_REG = 4;
   localparam int PPFS_FIELD_STRIDE = 4;
   localparam int PPFS_FUNC47_GROUP = 1;
   localparam int PPFS_FUNC811_GROUP = 2;

   typedef enum logic [1:0] {
      PPFS_IDLE = 2'h0,
      PPFS_ACK = 2'h1
   } ppfs_state_t;

   typedef struct packed {
      ppfs_state_t state;
      logic [7:0] bitRate;
      logic [15:0] dir;
      logic [15:0] func47;
      logic [15:0] func811;
      logic [15:0] prio;
      logic [15:0] pinOut;
      logic [15:0] pinMeta;
      logic [15:0] pinSync;
      logic [31:0] readData;
   } ppfs_regs_t;
endpackage

// [rtl/ppfs_port_pin_function_select.sv]
// What this block does
// RQ1: Per-pin direction bit; zero means input
// RQ2: Pin 5 direction one drives transmit line
// RQ3: Pin 11 direction zero is receive line
// RQ4: Pin 5 function 010 selects serial transmit
// RQ5: Pin 11 function 011 selects serial receive
// RQ6: Function 000 gives plain port I/O
// RQ7: Four 3-bit fields, bits 15/11/7/3 reserved
// RQ8: Serial interrupt priority in bits 3-0
// RQ9: Eight-bit bit-rate register for baud generator
// RQ10: Reserved function bits read zero, ignored
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module ppfs_port_pin_function_select
   import ppfs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   input wire logic [15:0] pinIn,
   output logic [15:0] pinOut,
   output logic [15:0] pinOutEn,
   input wire logic serialTxData,
   output logic serialRxData,
   output logic [7:0] serialBitRate,
   output logic [3:0] serialIrqPriority,
   output logic [15:0] interruptPriorityLow
);
   ppfs_regs_t r_reg;
   ppfs_regs_t r_next;
   logic txSel;
   logic rxSel;
   logic takeReq;
   logic takeWrite;
   logic takeRead;

   // Merge a 16-bit write honouring byte enables
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // Low byte lane only; the bit-rate register is one byte wide
   function automatic logic [7:0] merge8(input logic [7:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      merge8 = old;
      if (be[0]) begin
         merge8 = wd[7:0];
      end
   endfunction

   // Function code of a pin; pins outside 4-11 have no field in
   // this block and always act as plain port I/O
   function automatic logic [2:0] pin_code(input ppfs_regs_t r,
      input int pin);
      int off;
      pin_code = PPFS_FN_PORT;
      off = (pin % PPFS_FIELDS_PER_REG) * PPFS_FIELD_STRIDE;
      if (pin / PPFS_FIELDS_PER_REG == PPFS_FUNC47_GROUP) begin
         pin_code = r.func47[off +: PPFS_FUNC_W];
      end else if (pin / PPFS_FIELDS_PER_REG == PPFS_FUNC811_GROUP) begin
         pin_code = r.func811[off +: PPFS_FUNC_W];
      end
   endfunction

   // Read mux; unmapped index 7 reads zero
   function automatic logic [31:0] read_word(input ppfs_regs_t r,
      input logic [2:0] idx);
      case (idx)
         PPFS_IDX_BIT_RATE: begin
            read_word = {24'h00_0000, r.bitRate};
         end
         PPFS_IDX_DIR: begin
            read_word = {16'h0000, r.dir};
         end
         PPFS_IDX_FUNC_4_7: begin
            read_word = {16'h0000, r.func47};
         end
         PPFS_IDX_FUNC_8_11: begin
            read_word = {16'h0000, r.func811};
         end
         PPFS_IDX_PRIO: begin
            read_word = {16'h0000, r.prio};
         end
         PPFS_IDX_PIN_IN: begin
            read_word = {16'h0000, r.pinSync};
         end
         PPFS_IDX_PIN_OUT: begin
            read_word = {16'h0000, r.pinOut};
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   // Apply one taken write to a copy of the registers
   function automatic ppfs_regs_t write_regs(input ppfs_regs_t r,
      input logic [2:0] idx, input logic [31:0] wd, input logic [3:0] be);
      ppfs_regs_t n;
      n = r;
      case (idx)
         PPFS_IDX_BIT_RATE: begin
            n.bitRate = merge8(r.bitRate, wd, be);
         end
         PPFS_IDX_DIR: begin
            n.dir = merge16(r.dir, wd, be);
         end
         PPFS_IDX_FUNC_4_7: begin
            // RQ10: reserved bits dropped
            n.func47 = merge16(r.func47, wd, be) & PPFS_FUNC_MASK;
         end
         PPFS_IDX_FUNC_8_11: begin
            // RQ7: four fields, reserved zero
            n.func811 = merge16(r.func811, wd, be) & PPFS_FUNC_MASK;
         end
         PPFS_IDX_PRIO: begin
            n.prio = merge16(r.prio, wd, be);
         end
         PPFS_IDX_PIN_OUT: begin
            n.pinOut = merge16(r.pinOut, wd, be);
         end
         default: begin
            // Pin input is read-only; unmapped writes are dropped
         end
      endcase
      write_regs = n;
   endfunction

   // RQ4: pin 5 function transmit
   assign txSel = pin_code(r_reg, PPFS_TX_PIN) == PPFS_FN_TX;
   // RQ5: pin 11 function receive
   assign rxSel = pin_code(r_reg, PPFS_RX_PIN) == PPFS_FN_RX;

   // Pin drive per pin
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : gPin
         if (g == PPFS_TX_PIN) begin : gTx
            // RQ2: transmit drives output
            always_comb begin
               pinOutEn[g] = r_reg.dir[g];
               pinOut[g] = txSel ? serialTxData : r_reg.pinOut[g];
            end
         end else if (g == PPFS_RX_PIN) begin : gRx
            // RQ3: receive pin as input
            always_comb begin
               pinOutEn[g] = rxSel ? 1'b0 : r_reg.dir[g];
               pinOut[g] = r_reg.pinOut[g];
            end
         end else begin : gGpio
            // RQ1: direction bit per pin
            // RQ6: port function by default
            always_comb begin
               pinOutEn[g] = r_reg.dir[g];
               pinOut[g] = r_reg.pinOut[g];
            end
         end
      end
   endgenerate

   // Idle line is high when receive not routed
   assign serialRxData = rxSel ? r_reg.pinSync[PPFS_RX_PIN] : 1'b1;
   // RQ9: bit rate to baud generator
   assign serialBitRate = r_reg.bitRate;
   // RQ8: priority field bits 3-0
   assign serialIrqPriority = r_reg.prio[PPFS_PRIO_LSB +: PPFS_PRIO_W];
   assign interruptPriorityLow = r_reg.prio;
   assign avsReadData = r_reg.readData;
   // Taken only in IDLE, so a request held through ACK acts once
   assign takeReq = (avsRead | avsWrite) && r_reg.state == PPFS_IDLE;
   assign takeWrite = takeReq && avsWrite;
   assign takeRead = takeReq && !avsWrite;
   // One wait cycle: answer registered, released in ACK state
   assign avsWaitRequest = (avsRead | avsWrite) && r_reg.state != PPFS_ACK;

   always_comb begin
      r_next = r_reg;
      case (r_reg.state)
         PPFS_IDLE: begin
            if (takeWrite) begin
               r_next = write_regs(r_reg, avsAddress, avsWriteData,
                  avsByteEnable);
               r_next.state = PPFS_ACK;
            end else if (takeRead) begin
               r_next.readData = read_word(r_reg, avsAddress);
               r_next.state = PPFS_ACK;
            end
         end
         PPFS_ACK: begin
            r_next.state = PPFS_IDLE;
         end
         default: begin
            r_next.state = PPFS_IDLE;
         end
      endcase
      // After the write copy, so a write never stalls the synchroniser
      r_next.pinMeta = pinIn;
      r_next.pinSync = r_reg.pinMeta;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         r_reg.state <= PPFS_IDLE;
         r_reg.bitRate <= PPFS_RST_BIT_RATE;
         r_reg.dir <= PPFS_RST_DIR;
         r_reg.func47 <= PPFS_RST_FUNC;
         r_reg.func811 <= PPFS_RST_FUNC;
         r_reg.prio <= PPFS_RST_PRIO;
         r_reg.pinOut <= PPFS_RST_PIN_OUT;
         r_reg.pinMeta <= PPFS_RST_SYNC;
         r_reg.pinSync <= PPFS_RST_SYNC;
         r_reg.readData <= PPFS_RST_READ;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// [bench/ppfs_properties.sv]
`timescale 1ns/1ps
module ppfs_properties
   import ppfs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   input wire logic [31:0] avsReadData,
   input wire logic avsWaitRequest,
   input wire logic [15:0] pinOutEn,
   input wire logic serialRxData,
   input wire logic [7:0] serialBitRate,
   input wire logic [3:0] serialIrqPriority,
   input wire logic [15:0] interruptPriorityLow
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_req;
      (avsRead || avsWrite) && avsWaitRequest;
   endsequence
   sequence s_wr(logic [2:0] a);
      avsWrite && !avsWaitRequest && avsAddress == a && avsByteEnable[0];
   endsequence
   a_wait_once: assert property (s_req |=> !avsWaitRequest)
      else $error("wait not one cycle");
   a_rate_write: assert property (s_wr(PPFS_IDX_BIT_RATE) |->
      serialBitRate == avsWriteData[7:0]) else $error("rate not written");
   a_rate_hold: assert property (!(avsWrite && avsAddress == 3'h0)
      |=> $stable(serialBitRate)) else $error("rate changed");
   a_dir_write: assert property (s_wr(PPFS_IDX_DIR) |->
      pinOutEn[5] == avsWriteData[5] && pinOutEn[0] == avsWriteData[0])
      else $error("enable not from direction");
   a_prio_write: assert property (s_wr(PPFS_IDX_PRIO) |->
      serialIrqPriority == avsWriteData[3:0]) else $error("prio wrong");
   a_prio_field: assert property (s_wr(PPFS_IDX_PRIO) |->
      interruptPriorityLow[7:0] == avsWriteData[7:0])
      else $error("priority register not written");
   a_rsvd_zero: assert property (avsRead && !avsWaitRequest &&
      avsAddress inside {3'h2, 3'h3} |->
      (avsReadData[15:0] & ~PPFS_FUNC_MASK) == 16'h0000)
      else $error("reserved bit set");
   a_rx_idle: assert property (pinOutEn[11] |-> serialRxData)
      else $error("receive not idle");
endmodule
bind ppfs_port_pin_function_select ppfs_properties u_props (.clk_sys,
   .rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
   .avsReadData, .avsWaitRequest, .pinOutEn, .serialRxData,
   .serialBitRate, .serialIrqPriority, .interruptPriorityLow);

// [bench/tb_port_pin_function_select.sv]
`timescale 1ns/1ps
module tb_port_pin_function_select;
   import ppfs_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
   logic [2:0] avsAddress = 3'h0;
   logic [31:0] avsWriteData = 32'h0, avsReadData;
   logic [15:0] pinIn = 16'h0000, pinOut, pinOutEn, interruptPriorityLow;
   logic avsWaitRequest, serialTxData = 1'b0, serialRxData;
   logic [7:0] serialBitRate;
   logic [3:0] serialIrqPriority;
   int fails = 0, num_checks = 0;
   ppfs_port_pin_function_select dut (.clk_sys, .rst, .avsAddress,
      .avsRead, .avsWrite, .avsWriteData, .avsByteEnable(4'h3),
      .avsReadData, .avsWaitRequest, .pinIn, .pinOut, .pinOutEn,
      .serialTxData, .serialRxData, .serialBitRate, .serialIrqPriority,
      .interruptPriorityLow);
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Held until waitrequest is seen low; the watchdog bounds the wait
   task automatic bus(input logic [2:0] a, input logic [15:0] d, input w);
      @(posedge clk_sys);
      avsAddress <= a;
      avsWriteData <= {16'h0000, d};
      avsWrite <= w;
      avsRead <= !w;
      @(posedge clk_sys);
      while (avsWaitRequest !== 1'b0) @(posedge clk_sys);
      if (!w) check(avsReadData, {16'h0000, d});
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      bus(PPFS_IDX_BIT_RATE, 16'h0081, 1);
      bus(PPFS_IDX_BIT_RATE, 16'h0081, 0);
      check(serialBitRate, 8'h81);
      bus(PPFS_IDX_DIR, 16'h0820, 1);
      check(pinOutEn, 16'h0820);
      bus(PPFS_IDX_FUNC_4_7, 16'hFFFF, 1);
      bus(PPFS_IDX_FUNC_4_7, 16'h7777, 0);
      bus(PPFS_IDX_FUNC_4_7, 16'h0020, 1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         serialTxData <= i[0];
         @(negedge clk_sys);
         check(pinOut[5], i[0]);
      end
      bus(PPFS_IDX_FUNC_4_7, 16'h0000, 1);
      bus(PPFS_IDX_PIN_OUT, 16'hFFDF, 1);
      check(pinOut, 16'hFFDF);
      bus(PPFS_IDX_FUNC_8_11, 16'h3000, 1);
      check(pinOutEn[11], 1'b0);
      for (int i = 0; i < 2; i++) begin
         pinIn <= {4'h0, i[0], 11'h000};
         repeat (3) @(posedge clk_sys);
         check(serialRxData, i[0]);
      end
      bus(PPFS_IDX_PIN_IN, 16'h0000, 1);
      bus(PPFS_IDX_PIN_IN, 16'h0800, 0);
      pinIn <= 16'h0000;
      bus(PPFS_IDX_FUNC_8_11, 16'h0000, 1);
      @(negedge clk_sys);
      check({pinOutEn[11], serialRxData}, 2'h3);
      bus(PPFS_IDX_PRIO, 16'h000F, 1);
      check(serialIrqPriority, 4'hF);
      check(interruptPriorityLow, 16'h000F);
      bus(3'h7, 16'hFFFF, 1);
      bus(3'h7, 16'h0000, 0);
      stop_test();
   end
   initial begin
      #20000;
      fails++;
      stop_test();
   end
endmodule
